// >>> rtl/stereo_seq_pkg.sv
package stereo_seq_pkg;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int WORD_W       = 16;
    localparam int BYTE_W       = 8;
    localparam int COARSE_W     = 9;
    localparam int FINE_W       = 7;
    localparam int BITS_PER_HALF = 16;
    localparam int MSB_POS      = 15;
    localparam int BIT_CNT_W    = 5;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 5'h10;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_SYS_MHZ       = 100;
    localparam int SAMPLE_RATE_KHZ   = 48;
    localparam int SAMPLE_TIME_NS    = 5200;
    localparam int SAMPLE_CYCLES     = SAMPLE_TIME_NS * CLK_SYS_MHZ / 1000;
    localparam int BYPASS_DELAY_CYC  = 2;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] MSB_FLIP   = 16'h8000;

    // Byte pair sequence on the memory side
    typedef enum logic [2:0] {
        MEM_IDLE, MEM_WR_HI, MEM_WR_LO, MEM_RD_HI, MEM_RD_LO
    } mem_state_t;

    // Word travelling from link domain to system domain
    typedef struct packed {
        logic              chan;
        logic [WORD_W-1:0] data;
    } cap_word_t;

    // Memory bus control bundle
    typedef struct packed {
        logic [BYTE_W-1:0] wdata;
        logic              hi_en_n;
        logic              lo_en_n;
        logic              oe_n;
        logic              chan_addr;
    } mem_ctl_t;

endpackage : stereo_seq_pkg

// >>> rtl/stereo_converter_data_sequencer.sv
// How it works
// R1: Two channels, 48 kHz each, one 16-bit word per channel each stereo cycle.
// R2: Sample hold input high acquires; low starts conversion counting.
// R3: Coarse 9-bit counts until first trip, fine 7-bit until zero cross.
// R4: Result is coarse above fine, held in a 16-bit latch.
// R5: ADC shifts previous result MSB first on falling bit clock, phase low.
// R6: Capture shifter samples on rising bit clock; 16 clocks give a word.
// R7: Capture strobe loads the word into two holding byte latches.
// R8: On channel 1 latch phase rises, serial idles high, shifter switches input.
// R9: Channel 2 shifts for 16 clocks, then latches and writes like channel 1.
// R10: Word goes to memory bus high byte then low byte under enables.
// R11: Reads follow write order: high byte strobe first, low byte strobe next.
// R12: Output byte latches drive the DAC bus continuously except in self-test.
// R13: Self-test bypasses memory with separate latches; normal latches disabled. The code keeps loading them and only switches the DAC select.
// R14: Bypass latch strobe is a delayed copy of the capture strobe.
// R15: Word MSB is inverted before the DAC.
// R16: Channel 1 held while sample-hold low; deglitch samples both together.
// R17: Channel address bit alternates per byte pair and is never offset.
// R18: Shifter input follows phase: channel 1 low, channel 2 high.
// R19: Capture strobe comes only after all sixteen shift edges.
`timescale 1ns/1ns
`default_nettype none
module stereo_converter_data_sequencer
    import stereo_seq_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              bit_shift_clock,
    input  wire logic              adc1_serial,
    input  wire logic              adc2_serial,
    input  wire logic              self_test,
    input  wire logic [BYTE_W-1:0] memory_data_in,
    output logic [BYTE_W-1:0]      memory_data_bus,
    output logic                   memory_data_oe_n,
    output logic                   input_high_byte_enable_n,
    output logic                   input_low_byte_enable_n,
    output logic                   output_high_byte_strobe,
    output logic                   output_low_byte_strobe,
    output logic                   channel_addr,
    output logic                   word_phase_clock,
    output logic                   capture_latch_strobe,
    output logic                   bypass_latch_strobe,
    output logic                   sample_hold_n,
    output logic                   deglitch_sample,
    output logic [WORD_W-1:0]      dac_bus
);

    // ------------------------------------------------------------------
    // Link domain: capture shifter on the bit clock
    // ------------------------------------------------------------------
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic                 phase_reg;
    logic [WORD_W-1:0]    shift_reg;
    logic [WORD_W-1:0]    word_hold_reg;
    logic                 word_chan_reg;
    logic                 word_tgl_reg;
    logic [WORD_W-1:0]    ch2_shift_reg;
    wire  logic           serial_sel;
    wire  logic           half_done;

    // Input selection tracks the word phase; channel 2 comes from its own shifter
    assign serial_sel = phase_reg ? ch2_shift_reg[MSB_POS] : adc1_serial; // [R18] [R8]
    // Word is complete only after the sixteenth edge
    assign half_done  = (bit_cnt_reg == BIT_CNT_LAST - 5'h01); // [R19] [R6]

    // Shift MSB first on rising edge; toggle hands the word to clk_sys
    always_ff @(posedge bit_shift_clock or posedge reset) begin
        if (reset) begin
            bit_cnt_reg   <= '0;
            phase_reg     <= 1'b0;
            shift_reg     <= WORD_RESET;
            word_hold_reg <= WORD_RESET;
            word_chan_reg <= 1'b0;
            word_tgl_reg  <= 1'b0;
            ch2_shift_reg <= WORD_RESET;
        end else begin
            shift_reg <= {shift_reg[WORD_W-2:0], serial_sel}; // [R5] [R6]
            // Channel 2 is gathered beside channel 1, then replayed while phase is high
            ch2_shift_reg <= {ch2_shift_reg[WORD_W-2:0], phase_reg | adc2_serial}; // [R8] [R9]
            if (half_done) begin
                bit_cnt_reg   <= '0;
                word_hold_reg <= {shift_reg[WORD_W-2:0], serial_sel}; // [R7] [R9]
                word_chan_reg <= phase_reg;
                word_tgl_reg  <= ~word_tgl_reg;
                phase_reg     <= ~phase_reg; // [R8] [R1]
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Crossing: toggle synchroniser, word is stable for a half cycle
    // ------------------------------------------------------------------
    logic [2:0] tgl_sync_reg;
    logic [1:0] phase_sync_reg;
    logic [1:0] test_sync_reg;
    wire  logic word_arrive;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tgl_sync_reg   <= '0;
            phase_sync_reg <= '0;
            test_sync_reg  <= '0;
        end else if (clk_en) begin
            tgl_sync_reg   <= {tgl_sync_reg[1:0], word_tgl_reg};
            phase_sync_reg <= {phase_sync_reg[0], phase_reg};
            test_sync_reg  <= {test_sync_reg[0], self_test}; // Jumper pin, two flops
        end
    end
    assign word_arrive = tgl_sync_reg[2] ^ tgl_sync_reg[1];

    // ------------------------------------------------------------------
    // System domain: holding latches, memory sequence, DAC latches
    // ------------------------------------------------------------------
    cap_word_t  cap_reg;
    mem_state_t mem_state_reg;
    mem_state_t mem_state_next;
    mem_ctl_t   mem_ctl_reg;
    mem_ctl_t   mem_ctl_next;
    logic [BYTE_W-1:0] out_hi_reg;
    logic [BYTE_W-1:0] out_lo_reg;
    logic [WORD_W-1:0] bypass_word_reg;
    logic [WORD_W-1:0] dac_reg;
    logic [BYPASS_DELAY_CYC-1:0] strobe_dly_reg;
    logic              cap_strobe_reg;
    logic              rd_hi_reg;
    logic              rd_lo_reg;
    logic              ch1_held_reg;
    logic              deg_reg;
    logic              deg_pend_reg;
    logic [12:0]       hold_cnt_reg;
    logic              hold_n_reg;

    // Sixteen-bit word with its top bit flipped for the DAC coding
    function automatic logic [WORD_W-1:0] dac_code(input logic [WORD_W-1:0] w);
        dac_code = w ^ MSB_FLIP; // [R15]
    endfunction : dac_code

    // Capture strobe loads the two holding byte latches
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cap_reg        <= '0;
            cap_strobe_reg <= 1'b0;
            strobe_dly_reg <= '0;
        end else if (clk_en) begin
            cap_strobe_reg <= word_arrive; // [R7] [R19]
            strobe_dly_reg <= {strobe_dly_reg[BYPASS_DELAY_CYC-2:0], cap_strobe_reg}; // [R14]
            if (word_arrive) begin
                cap_reg.data <= word_hold_reg;
                cap_reg.chan <= word_chan_reg;
            end
        end
    end

    // Memory byte-pair sequence: write high, write low, read high, read low
    always_comb begin
        mem_state_next = mem_state_reg;
        mem_ctl_next   = mem_ctl_reg;
        mem_ctl_next.hi_en_n = 1'b1;
        mem_ctl_next.lo_en_n = 1'b1;
        mem_ctl_next.oe_n    = 1'b1;
        case (mem_state_reg)
            MEM_IDLE: begin
                if (cap_strobe_reg) begin
                    mem_state_next       = MEM_WR_HI;
                    mem_ctl_next.wdata   = cap_reg.data[WORD_W-1:BYTE_W]; // [R10]
                    mem_ctl_next.hi_en_n = 1'b0;
                    mem_ctl_next.oe_n    = 1'b0;
                    mem_ctl_next.chan_addr = cap_reg.chan; // [R17]
                end
            end
            MEM_WR_HI: begin
                mem_state_next       = MEM_WR_LO;
                mem_ctl_next.wdata   = cap_reg.data[BYTE_W-1:0]; // [R10]
                mem_ctl_next.lo_en_n = 1'b0;
                mem_ctl_next.oe_n    = 1'b0;
            end
            MEM_WR_LO: mem_state_next = MEM_RD_HI;
            MEM_RD_HI: mem_state_next = MEM_RD_LO; // [R11]
            MEM_RD_LO: mem_state_next = MEM_IDLE;
            default:   mem_state_next = MEM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_state_reg <= MEM_IDLE;
            mem_ctl_reg   <= '{wdata: 8'h00, hi_en_n: 1'b1, lo_en_n: 1'b1,
                               oe_n: 1'b1, chan_addr: 1'b0};
            rd_hi_reg     <= 1'b0;
            rd_lo_reg     <= 1'b0;
        end else if (clk_en) begin
            mem_state_reg <= mem_state_next;
            mem_ctl_reg   <= mem_ctl_next;
            rd_hi_reg     <= (mem_state_next == MEM_RD_HI); // [R11]
            rd_lo_reg     <= (mem_state_next == MEM_RD_LO); // [R11]
        end
    end

    // Output byte latches and bypass latch; high byte first gives the DAC settle time
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            out_hi_reg      <= 8'h00;
            out_lo_reg      <= 8'h00;
            bypass_word_reg <= WORD_RESET;
            dac_reg         <= MSB_FLIP;
        end else if (clk_en) begin
            if (rd_hi_reg) out_hi_reg <= memory_data_in; // [R11]
            if (rd_lo_reg) out_lo_reg <= memory_data_in; // [R11]
            if (strobe_dly_reg[BYPASS_DELAY_CYC-1]) bypass_word_reg <= cap_reg.data; // [R13] [R14]
            // Normal latches still load in self-test; the DAC selects the bypass word
            dac_reg <= test_sync_reg[1] ? dac_code(bypass_word_reg) // [R13]
                                 : dac_code({out_hi_reg, out_lo_reg}); // [R12] [R15]
        end
    end

    // Sample/hold and deglitch timing follow the word phase
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold_cnt_reg <= '0;
            hold_n_reg   <= 1'b0;
            ch1_held_reg <= 1'b0;
            deg_pend_reg <= 1'b0;
            deg_reg      <= 1'b0;
        end else if (clk_en) begin
            // Deglitch waits one cycle so the DAC shows the whole channel 2 word
            deg_reg      <= deg_pend_reg; // [R16]
            deg_pend_reg <= rd_lo_reg && cap_reg.chan && ch1_held_reg;
            if (rd_lo_reg && cap_reg.chan) ch1_held_reg <= 1'b0;
            // A channel 1 word opens the window; the set below wins over the clear
            if (cap_strobe_reg && !cap_reg.chan) begin
                hold_n_reg   <= 1'b1; // [R2] [R16]
                hold_cnt_reg <= 13'(SAMPLE_CYCLES - 1);
            end else if (hold_n_reg && (cap_strobe_reg || hold_cnt_reg == '0)) begin
                // A fast bit clock cuts the window at the channel 2 word
                hold_n_reg   <= 1'b0; // [R2] [R3] [R4]
                hold_cnt_reg <= '0;
                ch1_held_reg <= 1'b1; // [R16]
            end else if (hold_cnt_reg != '0) begin
                hold_cnt_reg <= hold_cnt_reg - 13'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs from flip-flops
    // ------------------------------------------------------------------
    assign memory_data_bus          = mem_ctl_reg.wdata;
    assign memory_data_oe_n         = mem_ctl_reg.oe_n;
    assign input_high_byte_enable_n = mem_ctl_reg.hi_en_n;
    assign input_low_byte_enable_n  = mem_ctl_reg.lo_en_n;
    assign channel_addr             = mem_ctl_reg.chan_addr;
    assign output_high_byte_strobe  = rd_hi_reg;
    assign output_low_byte_strobe   = rd_lo_reg;
    assign word_phase_clock         = phase_sync_reg[1];
    assign capture_latch_strobe     = cap_strobe_reg;
    assign bypass_latch_strobe      = strobe_dly_reg[BYPASS_DELAY_CYC-1];
    assign sample_hold_n            = hold_n_reg;
    assign deglitch_sample          = deg_reg;
    assign dac_bus                  = dac_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_HI_THEN_LO: assert property (@(posedge clk_sys) disable iff (reset)
        (clk_en && $fell(input_high_byte_enable_n)) |=> input_low_byte_enable_n == 1'b0) // [R10]
        else $error("low byte did not follow high byte");
    AST_WRITE_AFTER_STROBE: assert property (@(posedge clk_sys) disable iff (reset)
        (clk_en && capture_latch_strobe && mem_state_reg == MEM_IDLE) |=> !input_high_byte_enable_n) // [R7]
        else $error("strobe did not start write");
    AST_READ_ORDER: assert property (@(posedge clk_sys) disable iff (reset)
        (clk_en && output_high_byte_strobe) |=> output_low_byte_strobe) // [R11]
        else $error("read order broken");
    AST_BYPASS_DELAY: assert property (@(posedge clk_sys) disable iff (reset || !clk_en)
        capture_latch_strobe |-> ##2 bypass_latch_strobe) // [R14]
        else $error("bypass strobe not delayed copy");
    AST_MSB_FLIP: assert property (@(posedge clk_sys) disable iff (reset)
        (clk_en && test_sync_reg[1]) |=> dac_bus == ($past(bypass_word_reg) ^ MSB_FLIP)) // [R15]
        else $error("dac coding wrong");
    AST_NO_OVERLAP: assert property (@(posedge clk_sys) disable iff (reset)
        !(output_high_byte_strobe && output_low_byte_strobe)) // [R11]
        else $error("both read strobes");
    AST_HOLD_LEN: assert property (@(posedge clk_sys) disable iff (reset || !clk_en)
        $rose(sample_hold_n) |-> sample_hold_n[*8]) // [R2]
        else $error("sample interval short");
    AST_BIT_COUNT: assert property (@(posedge bit_shift_clock) disable iff (reset)
        bit_cnt_reg <= BIT_CNT_LAST - 5'h01) // [R6]
        else $error("bit count overrun");
    AST_DEG_WHILE_HELD: assert property (@(posedge clk_sys) disable iff (reset)
        deglitch_sample |-> !sample_hold_n) // [R16]
        else $error("deglitch while channel 1 still tracking");
    AST_HOLD_ENDS: assert property (@(posedge clk_sys) disable iff (reset || !clk_en)
        (capture_latch_strobe && cap_reg.chan) |=> !sample_hold_n) // [R2]
        else $error("hold window ran into channel 2");
    COV_HOLD_END: cover property (@(posedge clk_sys) $fell(sample_hold_n));
    COV_WRITE: cover property (@(posedge clk_sys) !input_low_byte_enable_n);
    COV_READ: cover property (@(posedge clk_sys) output_low_byte_strobe);
    COV_SELF: cover property (@(posedge clk_sys) self_test && bypass_latch_strobe);
    COV_DEG: cover property (@(posedge clk_sys) deglitch_sample);

endmodule : stereo_converter_data_sequencer
`default_nettype wire

// >>> verification/audio_far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module audio_far_side_model
    import stereo_seq_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              bit_shift_clock,
    input  wire logic [WORD_W-1:0] word1,
    input  wire logic [WORD_W-1:0] word2,
    input  wire logic              corrupt,
    input  wire logic [BYTE_W-1:0] memory_data_bus,
    input  wire logic              input_high_byte_enable_n,
    input  wire logic              input_low_byte_enable_n,
    input  wire logic              output_high_byte_strobe,
    input  wire logic              output_low_byte_strobe,
    input  wire logic              channel_addr,
    output logic                   adc1_serial,
    output logic                   adc2_serial,
    output logic [BYTE_W-1:0]      memory_data_in
);
    logic [4:0]        pos_reg;
    logic [WORD_W-1:0] sh1_reg;
    logic [WORD_W-1:0] sh2_reg;
    logic [BYTE_W-1:0] hi_reg [2];
    logic [BYTE_W-1:0] lo_reg [2];
    logic [BYTE_W-1:0] last_reg;
    // ------------------------------------------------------------------
    // Converter pair and delay memory
    // ------------------------------------------------------------------
    // Next words are taken at edge 24, well clear of the shifting half
    always_ff @(posedge bit_shift_clock or posedge reset) begin
        if (reset) begin
            pos_reg <= 5'h00;
            sh1_reg <= word1;
            sh2_reg <= word2;
        end else begin
            pos_reg <= pos_reg + 5'h01;
            if (pos_reg == 5'h17) begin
                sh1_reg <= word1;
                sh2_reg <= word2;
            end
        end
    end
    // Both converters shift while the phase is low, idle high otherwise
    always_ff @(negedge bit_shift_clock or posedge reset) begin
        if (reset) begin
            adc1_serial <= word1[15];
            adc2_serial <= word2[15];
        end else begin
            adc1_serial <= (pos_reg < 5'h10) ? sh1_reg[4'hf - pos_reg[3:0]] : 1'b1;
            adc2_serial <= (pos_reg < 5'h10) ? sh2_reg[4'hf - pos_reg[3:0]] : 1'b1;
        end
    end
    // Writes land on the clock; the last bus value is kept for the released state
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            last_reg <= 8'h00;
        end else begin
            if (!input_high_byte_enable_n) hi_reg[channel_addr] <= memory_data_bus;
            if (!input_low_byte_enable_n) lo_reg[channel_addr] <= memory_data_bus;
            last_reg <= memory_data_in;
        end
    end
    // Read answers while its strobe stands; a released bus shows the inverse
    always_comb begin
        if (output_high_byte_strobe) begin
            memory_data_in = hi_reg[channel_addr] ^ {BYTE_W{corrupt}};
        end else if (output_low_byte_strobe) begin
            memory_data_in = lo_reg[channel_addr] ^ {BYTE_W{corrupt}};
        end else begin
            memory_data_in = ~last_reg;
        end
    end
endmodule : audio_far_side_model
`default_nettype wire

// >>> verification/stereo_converter_data_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module stereo_converter_data_sequencer_test
    import stereo_seq_pkg::*;
;
    logic              clk_sys, reset, bit_shift_clock, self_test, corrupt;
    logic              adc1_serial, adc2_serial, memory_data_oe_n, channel_addr;
    logic              input_high_byte_enable_n, input_low_byte_enable_n;
    logic              output_high_byte_strobe, output_low_byte_strobe, word_phase_clock;
    logic              capture_latch_strobe, bypass_latch_strobe, sample_hold_n;
    logic              deglitch_sample;
    logic [BYTE_W-1:0] memory_data_in, memory_data_bus, seen_hi [2], seen_lo [2];
    logic [WORD_W-1:0] dac_bus, w1, w2, p1, p2;
    int                failures, checks, nwr, ndeg, deg_mark;

    stereo_converter_data_sequencer dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
        .bit_shift_clock(bit_shift_clock), .adc1_serial(adc1_serial), .adc2_serial(adc2_serial),
        .self_test(self_test), .memory_data_in(memory_data_in), .memory_data_bus(memory_data_bus),
        .memory_data_oe_n(memory_data_oe_n), .input_high_byte_enable_n(input_high_byte_enable_n),
        .input_low_byte_enable_n(input_low_byte_enable_n), .channel_addr(channel_addr),
        .output_high_byte_strobe(output_high_byte_strobe), .word_phase_clock(word_phase_clock),
        .output_low_byte_strobe(output_low_byte_strobe), .sample_hold_n(sample_hold_n),
        .capture_latch_strobe(capture_latch_strobe), .bypass_latch_strobe(bypass_latch_strobe),
        .deglitch_sample(deglitch_sample), .dac_bus(dac_bus));

    audio_far_side_model far (.clk_sys(clk_sys), .reset(reset), .bit_shift_clock(bit_shift_clock),
        .word1(w1), .word2(w2), .corrupt(corrupt), .memory_data_bus(memory_data_bus),
        .input_high_byte_enable_n(input_high_byte_enable_n), .channel_addr(channel_addr),
        .input_low_byte_enable_n(input_low_byte_enable_n), .adc1_serial(adc1_serial),
        .output_high_byte_strobe(output_high_byte_strobe), .adc2_serial(adc2_serial),
        .output_low_byte_strobe(output_low_byte_strobe), .memory_data_in(memory_data_in));

    // ------------------------------------------------------------------
    // Clocks, bus monitor and helpers
    // ------------------------------------------------------------------
    always #5 clk_sys = ~clk_sys;
    // Link clock of 125 ns, rising edges never on a system clock edge
    always begin
        #62 bit_shift_clock = 1'b1;
        #63 bit_shift_clock = 1'b0;
    end
    // Written bytes are kept per channel; sampled on the falling edge, clear of launch
    always @(negedge clk_sys) begin
        if (input_high_byte_enable_n === 1'b0) begin
            seen_hi[channel_addr] = memory_data_bus;
            nwr++;
        end
        if (input_low_byte_enable_n === 1'b0) seen_lo[channel_addr] = memory_data_bus;
        if (deglitch_sample === 1'b1) ndeg++;
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Bounded wait for the next capture strobe; a hang ends the run
    task automatic wait_strobe();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (capture_latch_strobe !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            failures++;
            $display("unexpected capture_latch_strobe expected 1 seen 0");
            end_of_test();
        end
    endtask : wait_strobe

    // One stereo cycle: loads words a/b for the next cycle, judges p1/p2
    task automatic stereo_cycle(input logic [15:0] a, input logic [15:0] b);
        int n, nw;
        wait_strobe();
        nw = nwr;
        if (deg_mark >= 0) check("deglitch_count", 16'(ndeg - deg_mark), 16'h0001);
        deg_mark = ndeg;
        n = 0;
        while (bypass_latch_strobe !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("bypass_delay", 16'(n), 16'(BYPASS_DELAY_CYC));
        check("phase_ch2", 16'(word_phase_clock), 16'h0001);
        w1 = a;
        w2 = b;
        wait_strobe();
        check("dac_ch1", dac_bus, p1 ^ MSB_FLIP);
        check("phase_ch1", 16'(word_phase_clock), 16'h0000);
        repeat (20) @(posedge clk_sys);
        #1;
        check("dac_ch2", dac_bus, p2 ^ MSB_FLIP);
        if (!self_test) begin
            check("mem_ch1", {seen_hi[0], seen_lo[0]}, p1);
            check("mem_ch2", {seen_hi[1], seen_lo[1]}, p2);
            check("write_pairs", 16'(nwr - nw), 16'h0002);
        end
        p1 = a;
        p2 = b;
    endtask : stereo_cycle

    task automatic t_reset();
        check("reset_dac", dac_bus, MSB_FLIP);
        check("reset_en", {input_high_byte_enable_n, input_low_byte_enable_n}, 16'h0003);
        check("reset_oe", {capture_latch_strobe, memory_data_oe_n}, 16'h0001);
        $display("test reset done");
    endtask : t_reset

    // Boundary words, back to back, sign bit both ways
    task automatic t_normal();
        logic [15:0] tab [6];
        tab = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h00ff, 16'hff01};
        for (int i = 0; i < 6; i += 2) begin
            stereo_cycle(tab[i], tab[i + 1]);
        end
        $display("test normal done");
    endtask : t_normal

    // Memory returns wrong bytes in the first two cycles, so only the bypass path can pass them
    task automatic t_self_test();
        self_test = 1'b1;
        corrupt = 1'b1;
        stereo_cycle(16'h1357, 16'h9bdf);
        stereo_cycle(16'h2468, 16'hace0);
        self_test = 1'b0;
        corrupt = 1'b0;
        stereo_cycle(16'h4321, 16'hbcde);
        stereo_cycle(16'h0f0f, 16'hf0f0);
        $display("test self_test done");
    endtask : t_self_test

    initial begin
        clk_sys = 1'b0;
        bit_shift_clock = 1'b0;
        reset = 1'b1;
        self_test = 1'b0;
        corrupt = 1'b0;
        w1 = 16'ha5c3;
        w2 = 16'h3c5a;
        p1 = w1;
        p2 = w2;
        deg_mark = -1;
        repeat (12) @(posedge clk_sys);
        #1;
        t_reset();
        reset = 1'b0;
        t_normal();
        t_self_test();
        end_of_test();
    end
endmodule : stereo_converter_data_sequencer_test
`default_nettype wire
